// ===== inc/fcr_pkg.sv
package fcr_pkg;
    // register indices; byte address is four times the index
    localparam logic [4:0] IDX_TX_THR   = 5'h11;
    localparam logic [4:0] IDX_RX_THR   = 5'h12;
    localparam logic [4:0] IDX_FLOW_CFG = 5'h13;
    localparam logic [4:0] IDX_PAUSE_T  = 5'h14;
    localparam logic [4:0] IDX_BP_TX    = 5'h15;
    localparam logic [4:0] IDX_BP_RX    = 5'h16;
    localparam logic [4:0] IDX_NP_TX    = 5'h17;
    localparam int         ADDR_W       = 7;
    // reset values
    localparam logic [15:0] RST_TX_THR   = 16'h0000;
    localparam logic [15:0] RST_RX_THR   = 16'h0000;
    localparam logic [15:0] RST_FLOW_CFG = 16'h0000;
    localparam logic [15:0] RST_PAUSE_T  = 16'h0000;
    localparam logic [15:0] RST_BP_TX    = 16'h0000;
    localparam logic [15:0] RST_NP_TX    = 16'h0000;
    // field positions
    localparam int BIT_ACK    = 14;
    localparam int BIT_TOGGLE = 11;
    localparam int BIT_MORE   = 15;
    // threshold encodings
    localparam logic [4:0]  TX_WM_RSVD   = 5'h1f;
    localparam logic [5:0]  AUTOSEND_ZERO = 6'h00;
    localparam logic [5:0]  AUTOSEND_RSVD = 6'h3f;
    localparam logic [10:0] AUTOSEND_MAX = 11'h3e0;
    localparam logic [7:0]  RX_WM_RSVD   = 8'hff;
    localparam logic [3:0]  PAUSE_AS_OFF = 4'h0;
    localparam logic [15:0] PAUSE_MIN    = 16'h0032;
    localparam logic [15:0] PAUSE_ZERO   = 16'h0000;
    // pause quantum of the remote station
    localparam int PAUSE_QUANTUM_NS = 512;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [4:0] wm_one;
        logic [4:0] wm_two;
        logic [5:0] autosend;
    } fcr_tx_thr_t;

    typedef struct packed {
        logic [7:0] wm_one;
        logic [7:0] wm_two;
    } fcr_rx_thr_t;

    typedef struct packed {
        logic       honour;
        logic [1:0] forward_sel;
        logic       addr_filter;
        logic       end_pause;
        logic [3:0] autosend;
        logic [6:0] rsvd;
    } fcr_flow_t;

    typedef struct packed {
        logic       more_pages;
        logic       ack;
        logic [1:0] remote_fault;
        logic [2:0] rsvd_hi;
        logic [1:0] pause_dir;
        logic       half_duplex;
        logic       full_duplex;
        logic [4:0] rsvd_lo;
    } fcr_base_page_t;
endpackage

// ===== rtl/fcr_regs.sv
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fcr_regs
    import fcr_pkg::*;
#(
    parameter int TX_LVL_W = 11,
    parameter int RX_LVL_W = 13
)(
    // clock and reset
    input  wire logic                clk_sys_in,
    input  wire logic                rst_b_in,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr_in,
    input  wire logic                s_axi_awvalid_in,
    output logic                     s_axi_awready_out,
    input  wire logic [31:0]         s_axi_wdata_in,
    input  wire logic [3:0]          s_axi_wstrb_in,
    input  wire logic                s_axi_wvalid_in,
    output logic                     s_axi_wready_out,
    // axi4-lite write response
    output logic [1:0]               s_axi_bresp_out,
    output logic                     s_axi_bvalid_out,
    input  wire logic                s_axi_bready_in,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0]   s_axi_araddr_in,
    input  wire logic                s_axi_arvalid_in,
    output logic                     s_axi_arready_out,
    output logic [31:0]              s_axi_rdata_out,
    output logic [1:0]               s_axi_rresp_out,
    output logic                     s_axi_rvalid_out,
    input  wire logic                s_axi_rready_in,
    // fifo occupancy and transmit start
    input  wire logic [TX_LVL_W-1:0] tx_fifo_words_in,
    input  wire logic [RX_LVL_W-1:0] rx_fifo_words_in,
    input  wire logic                tx_eof_write_in,
    output logic                     tx_watermark_one_out,
    output logic                     tx_watermark_two_out,
    output logic                     tx_start_out,
    output logic                     rx_watermark_one_out,
    output logic                     rx_watermark_two_out,
    // flow control
    input  wire logic                flow_request_pin_in,
    input  wire logic                rx_pause_seen_in,
    input  wire logic                rx_pause_da_match_in,
    output logic                     pause_send_out,
    output logic [15:0]              pause_time_out,
    output logic                     tx_pause_hold_out,
    output logic [1:0]               control_frame_forward_select_out,
    // auto-negotiation
    input  wire logic [15:0]         an_partner_page_in,
    input  wire logic                an_ack_in,
    input  wire logic                an_toggle_in,
    output logic [15:0]              an_base_page_out,
    output logic [15:0]              an_next_page_out
);

    // register storage
    fcr_tx_thr_t    tx_thr_reg;
    fcr_rx_thr_t    rx_thr_reg;
    fcr_flow_t      flow_reg;
    logic [15:0]    pause_t_reg;
    fcr_base_page_t bp_tx_reg;
    logic [15:0]    np_tx_reg;

    // axi handshake state
    logic              aw_got_reg;
    logic              w_got_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;

    // write channel acceptance, either order
    // a write completes in the cycle both halves are present
    wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
    wire w_take  = s_axi_wvalid_in && s_axi_wready_out;
    wire aw_have = aw_got_reg || aw_take;
    wire w_have  = w_got_reg || w_take;
    wire do_wr   = aw_have && w_have;
    wire [ADDR_W-1:0] wr_addr = aw_got_reg ? aw_addr_reg : s_axi_awaddr_in;
    wire [31:0]       wr_data = w_got_reg ? w_data_reg : s_axi_wdata_in;
    wire [3:0]        wr_strb = w_got_reg ? w_strb_reg : s_axi_wstrb_in;
    wire [4:0]        wr_idx  = wr_addr[ADDR_W-1:2];
    wire [15:0]       wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    assign s_axi_awready_out = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready_out  = !w_got_reg && !bvalid_reg;
    assign s_axi_bvalid_out  = bvalid_reg;
    assign s_axi_bresp_out   = bresp_reg;
    // the read side runs on its own, beside any write
    assign s_axi_arready_out = !rvalid_reg;
    assign s_axi_rvalid_out  = rvalid_reg;
    assign s_axi_rdata_out   = rdata_reg;
    assign s_axi_rresp_out   = rresp_reg;

    // write decode
    wire wr_tx  = do_wr && wr_idx == IDX_TX_THR;
    wire wr_rx  = do_wr && wr_idx == IDX_RX_THR;
    wire wr_fl  = do_wr && wr_idx == IDX_FLOW_CFG;
    wire wr_pt  = do_wr && wr_idx == IDX_PAUSE_T;
    wire wr_bp  = do_wr && wr_idx == IDX_BP_TX;
    wire wr_np  = do_wr && wr_idx == IDX_NP_TX;
    // the partner page index answers okay and stores nothing
    wire wr_ro  = do_wr && wr_idx == IDX_BP_RX;
    wire wr_hit = wr_tx || wr_rx || wr_fl || wr_pt || wr_bp || wr_np || wr_ro;

    // merge byte lanes into a stored word
    // a lane whose strobe is low keeps its old bits
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [15:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // readback words; ack and toggle come from the negotiation machine
    // stored bits in those positions are never shown
    wire [15:0] bp_tx_rd = {bp_tx_reg[15], an_ack_in,
                            bp_tx_reg[13:0]};
    wire [15:0] np_tx_rd = {np_tx_reg[15], an_ack_in, np_tx_reg[13:12],
                            an_toggle_in, np_tx_reg[10:0]};

    // read decode
    // unmapped indices read as zero with an error response
    wire [4:0] rd_idx = s_axi_araddr_in[ADDR_W-1:2];
    logic [15:0] rd_word;
    logic        rd_hit;
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_word = 16'h0000;
        unique case (rd_idx)
            IDX_TX_THR:   rd_word = tx_thr_reg;
            IDX_RX_THR:   rd_word = rx_thr_reg;
            IDX_FLOW_CFG: rd_word = flow_reg;
            IDX_PAUSE_T:  rd_word = pause_t_reg;
            IDX_BP_TX:    rd_word = bp_tx_rd;
            IDX_BP_RX:    rd_word = an_partner_page_in;
            IDX_NP_TX:    rd_word = np_tx_rd;
            default:      rd_hit  = 1'b0;
        endcase
    end

    // axi channel state
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                aw_addr_reg <= s_axi_awaddr_in;
            if (w_take)
            begin
                w_data_reg <= s_axi_wdata_in;
                w_strb_reg <= s_axi_wstrb_in;
            end
            // a channel that arrives alone waits here for its partner
            aw_got_reg <= aw_have && !do_wr;
            w_got_reg  <= w_have && !do_wr;
            // both readies stay low while the answer waits for bready
            if (do_wr)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready_in)
                bvalid_reg <= 1'b0;
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end
        else if (s_axi_arvalid_in && !rvalid_reg)
        begin
            rvalid_reg <= 1'b1;
            // the word stays frozen until rready takes it
            rdata_reg  <= {16'h0000, rd_word};
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready_in)
            rvalid_reg <= 1'b0;
    end

    // configuration registers; base page receive ignores writes
    // only byte lanes zero and one carry register bits
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            tx_thr_reg  <= RST_TX_THR;
            rx_thr_reg  <= RST_RX_THR;
            flow_reg    <= RST_FLOW_CFG;
            pause_t_reg <= RST_PAUSE_T;
            bp_tx_reg   <= RST_BP_TX;
            np_tx_reg   <= RST_NP_TX;
        end
        else
        begin
            if (wr_tx)
                tx_thr_reg <= merge(tx_thr_reg, wr_data[15:0], wr_mask);
            if (wr_rx)
                rx_thr_reg <= merge(rx_thr_reg, wr_data[15:0], wr_mask);
            if (wr_fl)
                flow_reg <= merge(flow_reg, wr_data[15:0], wr_mask);
            if (wr_pt)
                pause_t_reg <= merge(pause_t_reg, wr_data[15:0], wr_mask);
            if (wr_bp)
                bp_tx_reg <= merge(bp_tx_reg, wr_data[15:0], wr_mask);
            if (wr_np)
                np_tx_reg <= merge(np_tx_reg, wr_data[15:0], wr_mask);
        end
    end

    // transmit watermark levels: (code+1)*32 words, reserved never fires
    // code 11111 would give a level of 1024 words, hence the mask
    wire [TX_LVL_W-1:0] tx_lvl1 =
        TX_LVL_W'({6'h00, tx_thr_reg.wm_one} + 11'h001) << 5;
    wire [TX_LVL_W-1:0] tx_lvl2 =
        TX_LVL_W'({6'h00, tx_thr_reg.wm_two} + 11'h001) << 5;
    wire tx_wm1_hit = tx_thr_reg.wm_one != TX_WM_RSVD
                      && tx_fifo_words_in >= tx_lvl1;
    wire tx_wm2_hit = tx_thr_reg.wm_two != TX_WM_RSVD
                      && tx_fifo_words_in >= tx_lvl2;

    // autosend level: code 0 is 992 words, else (code+1)*8 words
    // the reserved top code falls back to the longest wait
    wire [TX_LVL_W-1:0] as_lvl =
        (tx_thr_reg.autosend == AUTOSEND_ZERO ||
         tx_thr_reg.autosend == AUTOSEND_RSVD)
        ? TX_LVL_W'(AUTOSEND_MAX)
        : TX_LVL_W'({5'h00, tx_thr_reg.autosend} + 11'h001) << 3;
    wire tx_go = tx_fifo_words_in >= as_lvl || tx_eof_write_in;

    // receive watermark levels: (code+1)*16 words, reserved never fires
    // levels count four-byte words, as the fifo reports them
    wire [RX_LVL_W-1:0] rx_lvl1 =
        RX_LVL_W'({5'h00, rx_thr_reg.wm_one} + 13'h0001) << 4;
    wire [RX_LVL_W-1:0] rx_lvl2 =
        RX_LVL_W'({5'h00, rx_thr_reg.wm_two} + 13'h0001) << 4;
    wire rx_wm1_hit = rx_thr_reg.wm_one != RX_WM_RSVD
                      && rx_fifo_words_in >= rx_lvl1;
    wire rx_wm2_hit = rx_thr_reg.wm_two != RX_WM_RSVD
                      && rx_fifo_words_in >= rx_lvl2;

    // pin disable sits in the lowest spare bit of the flow register
    logic flow_request_pin_disable_w;
    assign flow_request_pin_disable_w = flow_reg.rsvd[0];

    // pause autosend: code*1024 bytes is code*256 four-byte words
    wire [RX_LVL_W-1:0] ps_lvl =
        RX_LVL_W'({9'h000, flow_reg.autosend} << 8);
    wire ps_occ_hit = flow_reg.autosend != PAUSE_AS_OFF
                      && rx_fifo_words_in >= ps_lvl;
    // the pin counts only while its disable bit is clear
    wire pin_live = flow_request_pin_in
                    && !flow_request_pin_disable_w;
    wire pause_req = ps_occ_hit || pin_live;

    // pause time sent, never below the minimum
    // the floor applies to a programmed zero as well
    wire [15:0] pt_send = (pause_t_reg <= PAUSE_MIN)
                          ? PAUSE_MIN : pause_t_reg;

    // pause frame requests: rising request sends time, pin release zero
    // a rising request wins over an end pause in the same cycle
    // the time word is held after the pulse for the frame builder
    logic pause_req_reg;
    logic pin_live_reg;
    logic send_reg;
    logic [15:0] ptime_reg;
    wire end_pause = pin_live_reg && !pin_live && flow_reg.end_pause
                     && !flow_request_pin_disable_w;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            pause_req_reg <= 1'b0;
            pin_live_reg  <= 1'b0;
            send_reg      <= 1'b0;
            ptime_reg     <= PAUSE_ZERO;
        end
        else
        begin
            pause_req_reg <= pause_req;
            pin_live_reg  <= pin_live;
            send_reg      <= (pause_req && !pause_req_reg) || end_pause;
            if (pause_req && !pause_req_reg)
                ptime_reg <= pt_send;
            else if (end_pause)
                ptime_reg <= PAUSE_ZERO;
        end
    end

    // received pause validity and transmitter hold
    // one-cycle trigger only; the transmitter times the pause itself
    wire rx_pause_ok = rx_pause_seen_in
        && (!flow_reg.addr_filter || rx_pause_da_match_in);
    logic hold_reg;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
            hold_reg <= 1'b0;
        else
            hold_reg <= rx_pause_ok && flow_reg.honour;
    end

    // registered status and data outputs
    logic [4:0] flags_reg;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
            flags_reg <= 5'h00;
        else
            flags_reg <= {tx_wm1_hit, tx_wm2_hit, tx_go,
                          rx_wm1_hit, rx_wm2_hit};
    end

    assign tx_watermark_one_out = flags_reg[4];
    assign tx_watermark_two_out = flags_reg[3];
    assign tx_start_out         = flags_reg[2];
    assign rx_watermark_one_out = flags_reg[1];
    assign rx_watermark_two_out = flags_reg[0];
    assign pause_send_out       = send_reg;
    assign pause_time_out       = ptime_reg;
    assign tx_pause_hold_out    = hold_reg;
    assign control_frame_forward_select_out = flow_reg.forward_sel;

    // pages to the negotiation machine: pause bits 8:7, duplex 6 and 5
    assign an_base_page_out = bp_tx_reg;
    assign an_next_page_out = np_tx_reg;

endmodule
`default_nettype wire

// ===== verif/fcr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fcr_regs_monitor (
    // clock and reset
    input wire logic        clk_sys_in,
    input wire logic        rst_b_in,
    // register bus handshakes
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wready_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out,
    // transmit start and pause
    input wire logic        tx_eof_write_in,
    input wire logic        tx_start_out,
    input wire logic        rx_pause_seen_in,
    input wire logic        tx_pause_hold_out,
    input wire logic        pause_send_out,
    input wire logic [15:0] pause_time_out
);
    // every check samples on the system clock and sleeps in reset
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    a_eof_start: assert property (tx_eof_write_in |=> tx_start_out)
        else $error("end of frame did not start transmit");
    a_hold_cause: assert property (
        tx_pause_hold_out |-> $past(rx_pause_seen_in))
        else $error("pause hold without a received pause frame");
    a_pause_floor: assert property (
        pause_send_out && pause_time_out != 16'h0000
        |-> pause_time_out >= 16'h0032)
        else $error("pause time below floor");
    a_b_drop: assert property (
        s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
        else $error("write response not retired");
    a_r_drop: assert property (
        s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
        else $error("read data not retired");
    a_ar_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read address taken while data pending");
    a_w_block: assert property (s_axi_bvalid_out
        |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write taken while response pending");
    a_r_answer: assert property (
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read answer late");
    a_r_upper: assert property (
        s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0000)
        else $error("upper read half not zero");
endmodule
bind fcr_regs fcr_regs_monitor u_mon (.*);
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fcr_pkg::*;
    // design ports
    logic              clk_sys_in, rst_b_in, tx_eof_write_in;
    logic [ADDR_W-1:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic              s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
    logic              s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out;
    logic              s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic              s_axi_rvalid_out, tx_start_out, pause_send_out;
    logic [31:0]       s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0]        s_axi_wstrb_in;
    logic [1:0]        s_axi_bresp_out, s_axi_rresp_out;
    logic [1:0]        control_frame_forward_select_out;
    logic [10:0]       tx_fifo_words_in;
    logic [12:0]       rx_fifo_words_in;
    logic              flow_request_pin_in, rx_pause_seen_in;
    logic              rx_pause_da_match_in, an_ack_in, an_toggle_in;
    logic              tx_watermark_one_out, tx_watermark_two_out;
    logic              rx_watermark_one_out, rx_watermark_two_out;
    logic              tx_pause_hold_out;
    logic [15:0]       pause_time_out, an_partner_page_in;
    logic [15:0]       an_base_page_out, an_next_page_out;
    // bench bookkeeping
    int                n_fail, total_checks;
    logic [5:0]        asc [3] = '{6'h01, 6'h3e, 6'h00};
    logic [10:0]       asl [3] = '{11'd16, 11'd504, 11'd992};

    fcr_regs dut (.*);

    // free-running system clock
    initial
    begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // one write: address and data offered together, each released when taken
    task automatic wr(input logic [6:0] a, input logic [15:0] d,
                      input logic [1:0] er);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk_sys_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= {16'h0000, d};
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge clk_sys_in);
            if (s_axi_awready_out) ad = 1'b1;
            if (s_axi_wready_out) wd = 1'b1;
            if (ad) s_axi_awvalid_in <= 1'b0;
            if (wd) s_axi_wvalid_in <= 1'b0;
        end
        do @(posedge clk_sys_in); while (!s_axi_bvalid_out);
        s_axi_bready_in <= 1'b0;
        chk({30'h0, s_axi_bresp_out}, {30'h0, er});
    endtask

    // one read; data compared only on an okay answer
    task automatic rd(input logic [6:0] a, input logic [15:0] ev,
                      input logic [1:0] er);
        @(posedge clk_sys_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do @(posedge clk_sys_in); while (!s_axi_arready_out);
        s_axi_arvalid_in <= 1'b0;
        do @(posedge clk_sys_in); while (!s_axi_rvalid_out);
        s_axi_rready_in <= 1'b0;
        chk({30'h0, s_axi_rresp_out}, {30'h0, er});
        if (er == RESP_OKAY) chk(s_axi_rdata_out, {16'h0000, ev});
    endtask

    // fill levels; e is start, tx marks one and two, rx marks one and two
    task automatic lvl(input logic [10:0] tw, input logic [12:0] rw,
                       input logic [4:0] e);
        @(posedge clk_sys_in);
        tx_fifo_words_in <= tw;
        rx_fifo_words_in <= rw;
        repeat (2) @(posedge clk_sys_in);
        chk({27'h0, tx_start_out, tx_watermark_one_out, tx_watermark_two_out,
             rx_watermark_one_out, rx_watermark_two_out}, {27'h0, e});
    endtask

    // move pin and rx level, then watch four cycles for a pause request
    task automatic pz(input logic p, input logic [12:0] w, input logic es,
                      input logic [15:0] et);
        logic seen;
        logic [15:0] tm;
        seen = 1'b0;
        tm = 16'h0000;
        @(posedge clk_sys_in);
        flow_request_pin_in <= p;
        rx_fifo_words_in <= w;
        repeat (4)
        begin
            @(posedge clk_sys_in);
            if (pause_send_out === 1'b1) seen = 1'b1;
            if (pause_send_out === 1'b1) tm = pause_time_out;
        end
        chk({31'h0, seen}, {31'h0, es});
        if (es) chk({16'h0, tm}, {16'h0, et});
    endtask

    // one received pause frame under a given flow setting
    task automatic hd(input logic [15:0] f, input logic m, input logic e);
        wr(7'h4c, f, RESP_OKAY);
        @(posedge clk_sys_in);
        rx_pause_seen_in <= 1'b1;
        rx_pause_da_match_in <= m;
        @(posedge clk_sys_in);
        rx_pause_seen_in <= 1'b0;
        @(posedge clk_sys_in);
        chk({31'h0, tx_pause_hold_out}, {31'h0, e});
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        n_fail++;
        conclude();
    end

    // main sequence
    initial
    begin
        {rst_b_in, tx_eof_write_in, s_axi_awvalid_in, s_axi_wvalid_in} = '0;
        {s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
        {tx_fifo_words_in, rx_fifo_words_in, flow_request_pin_in} = '0;
        {rx_pause_seen_in, rx_pause_da_match_in, an_ack_in} = '0;
        an_toggle_in = 1'b0;
        s_axi_wstrb_in = 4'hf;
        an_partner_page_in = 16'h5a3c;
        repeat (20) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        for (int i = 17; i <= 23; i++)
            rd(7'(i * 4), (i == 22) ? 16'h5a3c : '0, RESP_OKAY);
        rd(7'h00, 16'h0000, RESP_SLVERR);
        rd(7'h60, 16'h0000, RESP_SLVERR);
        wr(7'h40, 16'hffff, RESP_SLVERR);
        wr(7'h54, 16'hffff, RESP_OKAY);
        rd(7'h54, 16'hbfff, RESP_OKAY);
        @(posedge clk_sys_in);
        an_ack_in <= 1'b1;
        rd(7'h54, 16'hffff, RESP_OKAY);
        for (int k = 0; k < 4; k++)
        begin
            wr(7'h54, {7'h00, 2'(k), k[0], ~k[0], 5'h00}, RESP_OKAY);
            chk({16'h0, an_base_page_out & 16'h01e0},
                {23'h0, 2'(k), k[0], ~k[0], 5'h00});
        end
        wr(7'h58, 16'hffff, RESP_OKAY);
        rd(7'h58, 16'h5a3c, RESP_OKAY);
        wr(7'h5c, 16'hffff, RESP_OKAY);
        rd(7'h5c, 16'hf7ff, RESP_OKAY);
        @(posedge clk_sys_in);
        an_toggle_in <= 1'b1;
        an_ack_in <= 1'b0;
        rd(7'h5c, 16'hbfff, RESP_OKAY);
        chk({31'h0, an_next_page_out[15]}, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            wr(7'h44, {5'h1f, 5'h00, asc[i]}, RESP_OKAY);
            lvl(asl[i] - 11'd1, '0, {2'b00, asl[i] > 11'd32, 2'b00});
            lvl(asl[i], 13'd0, {2'b10, asl[i] >= 11'd32, 2'b00});
        end
        wr(7'h44, {5'h1e, 5'h1f, 6'h3e}, RESP_OKAY);
        lvl(11'd991, 13'd0, 5'b10000);
        lvl(11'd992, 13'd0, 5'b11000);
        wr(7'h44, 16'h0000, RESP_OKAY);
        lvl(11'd0, 13'd0, 5'b00000);
        @(posedge clk_sys_in);
        tx_eof_write_in <= 1'b1;
        @(posedge clk_sys_in);
        tx_eof_write_in <= 1'b0;
        @(posedge clk_sys_in);
        chk({31'h0, tx_start_out}, 32'h1);
        wr(7'h48, 16'hfffe, RESP_OKAY);
        lvl(11'd0, 13'd4079, 5'b00000);
        lvl(11'd0, 13'd4080, 5'b00001);
        wr(7'h48, 16'h00ff, RESP_OKAY);
        lvl(11'd0, 13'd16, 5'b00010);
        wr(7'h50, 16'h0020, RESP_OKAY);
        pz(1'b0, 13'd8191, 1'b0, 16'h0000);
        pz(1'b0, 13'd0, 1'b0, 16'h0000);
        wr(7'h4c, 16'h0080, RESP_OKAY);
        pz(1'b0, 13'd255, 1'b0, 16'h0000);
        pz(1'b0, 13'd256, 1'b1, 16'h0032);
        wr(7'h50, 16'h1234, RESP_OKAY);
        wr(7'h4c, 16'h0780, RESP_OKAY);
        pz(1'b0, 13'd3839, 1'b0, 16'h0000);
        pz(1'b0, 13'd3840, 1'b1, 16'h1234);
        pz(1'b0, 13'd0, 1'b0, 16'h0000);
        wr(7'h4c, 16'h0800, RESP_OKAY);
        pz(1'b1, 13'd0, 1'b1, 16'h1234);
        pz(1'b0, 13'd0, 1'b1, 16'h0000);
        wr(7'h4c, 16'h0801, RESP_OKAY);
        pz(1'b1, 13'd0, 1'b0, 16'h0000);
        pz(1'b0, 13'd0, 1'b0, 16'h0000);
        hd(16'h9000, 1'b0, 1'b0);
        hd(16'h9000, 1'b1, 1'b1);
        hd(16'h8000, 1'b0, 1'b1);
        hd(16'h1000, 1'b1, 1'b0);
        hd(16'hf000, 1'b1, 1'b1);
        chk({30'h0, control_frame_forward_select_out}, 32'h3);
        // a write with only lane zero enabled keeps the upper byte
        @(posedge clk_sys_in);
        s_axi_wstrb_in <= 4'h1;
        wr(7'h50, 16'hffff, RESP_OKAY);
        s_axi_wstrb_in <= 4'hf;
        rd(7'h50, 16'h12ff, RESP_OKAY);
        conclude();
    end
endmodule
`default_nettype wire
